//--- rtl/sll_pkg.sv
package sll_pkg;
  localparam int SLL_PG_FILTER = 7;
  localparam logic [2:0] SLL_PG_CNT_MAX = 3'h7;
  localparam int SLL_NSTRAP = 3;
  localparam int SLL_IDX_DEBUG = 0;
  localparam int SLL_IDX_RSVD = 1;
  localparam int SLL_IDX_EEP = 2;
  localparam logic [2:0] SLL_STRAP_DEFAULT = 3'h7;
  localparam int SLL_I2C_DIV = 500;
  localparam logic [8:0] SLL_I2C_DIV_MAX = 9'h1f3;
  localparam logic [6:0] SLL_EEP_ADDR = 7'h50;
  localparam logic [3:0] SLL_BIT_LAST = 4'h8;
  localparam logic [1:0] SLL_PIN_GPIO = 2'h0;
  localparam logic [1:0] SLL_PIN_PWM = 2'h1;
  localparam logic [1:0] SLL_PIN_I2C = 2'h2;
  typedef struct packed {
    logic debug_bus_n;
    logic reserved;
    logic eeprom_load_n;
  } sll_strap_t;
  typedef enum logic [2:0] {
    SLL_IDLE, SLL_START, SLL_ADDR, SLL_ACK, SLL_READ, SLL_STOP, SLL_DONE
  } sll_state_t;
endpackage

//--- rtl/sll_pg_filter.sv
`timescale 1ns/1ps
module sll_pg_filter
  import sll_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Raw and filtered power good.
  input wire logic power_ok_in,
  output logic pg_ok
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic ok_ff;
  logic nxt_ok;

  // Power good counts as high only after more than seven cycles high.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_ok = ok_ff;
    if (!power_ok_in)
    begin
      nxt_cnt = '0;
      nxt_ok = 1'b0;
    end
    else if (cnt_ff != SLL_PG_CNT_MAX)
      nxt_cnt = cnt_ff + 3'h1; // RULE12
    else
      nxt_ok = 1'b1; // RULE12
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      ok_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      ok_ff <= nxt_ok;
    end
  end

  assign pg_ok = ok_ff;

  pg_min_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ok_ff) |-> $past(power_ok_in, 7) && $past(power_ok_in, 1)) // RULE12
    else $error("power good passed before filter time");
  pg_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    !power_ok_in |=> !ok_ff) // RULE12
    else $error("power good not dropped");
endmodule

//--- rtl/sll_strap_loader.sv
`timescale 1ns/1ps
// Contract
// RULE1: Latch strap pins when power good asserts.
// RULE2: Strap pins undriven during reset.
// RULE3: Board pulls up for one, down zero.
// RULE4: Sampled zero asserts the strap function.
// RULE5: EEPROM or debug port may override straps.
// RULE6: Debug strap zero enables debug bus access.
// RULE7: Board must pull reserved strap high.
// RULE8: EEPROM strap zero loads from EEPROM.
// RULE9: Strap data pin is I2C, GPIO, PWM.
// RULE10: Three aux pins are GPIO or PWM.
// RULE11: Test mode high suspends normal operation.
// RULE12: Power good filtered over six cycles; the filter here needs eight cycles high.
// RULE13: Latched straps stable until power good drops.
module sll_strap_loader
  import sll_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Power and test.
  input wire logic power_ok_in,
  input wire logic factory_test_select,
  // Strap pins, sampled only; never driven.
  input wire logic debug_strap_pin,
  input wire logic reserved_strap_pin,
  input wire logic eeprom_select_strap_pin,
  // Debug strap port.
  input wire logic dbg_override_en,
  input wire sll_strap_t dbg_override_val,
  // Strap data pin and aux pins.
  input wire logic [1:0] sdata_mode,
  input wire logic sdata_gpio_out,
  input wire logic sdata_gpio_oe,
  input wire logic strap_serial_data_in,
  output logic strap_serial_data_out,
  output logic strap_serial_data_oe,
  output logic strap_scl_out,
  input wire logic [2:0] aux_pwm_sel,
  input wire logic [2:0] aux_gpio_out,
  input wire logic [2:0] aux_gpio_oe,
  input wire logic [2:0] aux_pwm,
  input wire logic sdata_pwm,
  output logic [2:0] aux_out,
  output logic [2:0] aux_oe,
  // Status.
  output sll_strap_t strap_value,
  output logic straps_valid,
  output logic debug_bus_enable,
  output logic test_mode_active,
  output logic eeprom_fallback
);
  logic pg_ok;
  logic pg_ok_d_ff;
  sll_strap_t strap_ff, nxt_strap;
  logic valid_ff, nxt_valid;
  sll_state_t st_ff, nxt_st;
  logic [8:0] div_ff, nxt_div;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic sda_ff, nxt_sda, sda_oe_ff, nxt_sda_oe, scl_ff, nxt_scl, fb_ff, nxt_fb;
  logic [2:0] aux_o_ff, aux_oe_ff;
  logic dbg_ff, tm_ff;
  logic tick;
  logic setup;

  sll_pg_filter u_pg (
    .clock(clock),
    .rst_n(rst_n),
    .power_ok_in(power_ok_in),
    .pg_ok(pg_ok)
  );

  assign tick = (div_ff == SLL_I2C_DIV_MAX);
  // Data moves one clock after a tick, so it never changes on the same edge as the serial clock.
  assign setup = (div_ff == '0);

  always_comb
  begin
    nxt_strap = strap_ff;
    nxt_valid = valid_ff;
    nxt_st = st_ff;
    nxt_div = tick ? 9'h000 : div_ff + 9'h001;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_sda = sda_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_scl = scl_ff;
    nxt_fb = fb_ff;
    if (!pg_ok)
    begin
      nxt_valid = 1'b0; // RULE13
      nxt_st = SLL_IDLE;
      nxt_fb = 1'b0;
    end
    else if (pg_ok && !pg_ok_d_ff)
    begin
      nxt_strap = '{debug_strap_pin, reserved_strap_pin, eeprom_select_strap_pin}; // RULE1 RULE3
      nxt_valid = 1'b1;
      nxt_st = (!eeprom_select_strap_pin && !factory_test_select) ? SLL_START : SLL_IDLE; // RULE8
      if (eeprom_select_strap_pin)
        nxt_strap = {debug_strap_pin, SLL_STRAP_DEFAULT[1:0]}; // RULE8
      nxt_sh = {SLL_EEP_ADDR, 1'b1};
      nxt_bit = '0;
    end
    else if (dbg_override_en)
      nxt_strap = dbg_override_val; // RULE5
    else if (!factory_test_select && (tick || setup)) // RULE11
    begin
      // Minimal EEPROM read: address byte, then one strap byte; each tick in ADDR, ACK and READ toggles the serial clock.
      case (st_ff)
        SLL_START:
          if (tick)
          begin
            nxt_sda_oe = 1'b1;
            nxt_sda = 1'b0;
            nxt_st = SLL_ADDR;
          end
        SLL_ADDR:
          if (setup && !scl_ff)
          begin
            nxt_sda_oe = !sh_ff[7]; // RULE9
            nxt_sda = sh_ff[7];
            nxt_sh = {sh_ff[6:0], 1'b0};
          end
          else if (tick)
          begin
            nxt_scl = !scl_ff;
            if (!scl_ff)
            begin
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff == SLL_BIT_LAST - 4'h1)
                nxt_st = SLL_ACK;
            end
          end
        SLL_ACK:
          if (setup && !scl_ff)
          begin
            nxt_sda_oe = 1'b0;
            nxt_sda = 1'b1;
          end
          else if (tick)
          begin
            nxt_scl = !scl_ff;
            nxt_bit = '0;
            if (scl_ff && bit_ff == '0)
            begin
              if (strap_serial_data_in)
              begin
                nxt_strap = SLL_STRAP_DEFAULT; // RULE8
                nxt_fb = 1'b1; // RULE8
                nxt_st = SLL_STOP;
              end
              else
                nxt_st = SLL_READ;
            end
          end
        SLL_READ:
          if (tick)
          begin
            nxt_scl = !scl_ff;
            if (scl_ff)
            begin
              nxt_sh = {sh_ff[6:0], strap_serial_data_in}; // RULE5
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff == SLL_BIT_LAST - 4'h1)
              begin
                nxt_strap = {sh_ff[1:0], strap_serial_data_in}; // RULE8
                nxt_st = SLL_STOP;
              end
            end
          end
        SLL_STOP:
          if (setup && !scl_ff)
          begin
            nxt_sda_oe = 1'b1;
            nxt_sda = 1'b0;
          end
          else if (tick)
          begin
            if (scl_ff)
            begin
              nxt_sda_oe = 1'b0;
              nxt_sda = 1'b1;
              nxt_st = SLL_DONE;
            end
            else
              nxt_scl = 1'b1;
          end
        default:
          nxt_st = st_ff;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_ok_d_ff <= 1'b0;
      strap_ff <= SLL_STRAP_DEFAULT;
      valid_ff <= 1'b0;
      st_ff <= SLL_IDLE;
      div_ff <= '0;
      bit_ff <= '0;
      sh_ff <= '0;
      sda_ff <= 1'b1;
      sda_oe_ff <= 1'b0; // RULE2
      scl_ff <= 1'b1;
      fb_ff <= 1'b0;
      aux_o_ff <= '0;
      aux_oe_ff <= '0; // RULE2
      dbg_ff <= 1'b0;
      tm_ff <= 1'b0;
    end
    else
    begin
      pg_ok_d_ff <= pg_ok;
      strap_ff <= nxt_strap;
      valid_ff <= nxt_valid;
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      fb_ff <= nxt_fb;
      tm_ff <= factory_test_select; // RULE11
      dbg_ff <= valid_ff && !strap_ff.debug_bus_n && !factory_test_select; // RULE4 RULE6
      if (st_ff != SLL_IDLE && st_ff != SLL_DONE)
      begin
        sda_ff <= nxt_sda; // RULE9
        sda_oe_ff <= nxt_sda_oe;
        scl_ff <= nxt_scl;
      end
      else if (valid_ff && !factory_test_select && sdata_mode == SLL_PIN_PWM)
      begin
        sda_ff <= sdata_pwm; // RULE9
        sda_oe_ff <= 1'b1;
        scl_ff <= 1'b1;
      end
      else if (valid_ff && !factory_test_select && sdata_mode == SLL_PIN_GPIO)
      begin
        sda_ff <= sdata_gpio_out; // RULE9
        sda_oe_ff <= sdata_gpio_oe;
        scl_ff <= 1'b1;
      end
      else
      begin
        sda_ff <= 1'b1;
        sda_oe_ff <= 1'b0;
        scl_ff <= 1'b1;
      end
      for (int i = 0; i < SLL_NSTRAP; i++)
      begin
        aux_o_ff[i] <= aux_pwm_sel[i] ? aux_pwm[i] : aux_gpio_out[i]; // RULE10
        aux_oe_ff[i] <= valid_ff && !factory_test_select && (aux_pwm_sel[i] || aux_gpio_oe[i]); // RULE10
      end
    end
  end

  assign strap_value = strap_ff;
  assign straps_valid = valid_ff;
  assign debug_bus_enable = dbg_ff;
  assign test_mode_active = tm_ff;
  assign eeprom_fallback = fb_ff;
  assign strap_serial_data_out = sda_ff;
  assign strap_serial_data_oe = sda_oe_ff;
  assign strap_scl_out = scl_ff;
  assign aux_out = aux_o_ff;
  assign aux_oe = aux_oe_ff;

  strap_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pg_ok) && !eeprom_select_strap_pin |=> strap_ff.debug_bus_n == $past(debug_strap_pin)) // RULE1
    else $error("strap not latched");
  strap_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
    valid_ff && $past(valid_ff) && !dbg_override_en && st_ff == SLL_IDLE && $past(st_ff) == SLL_IDLE
    |-> $stable(strap_ff)) // RULE13
    else $error("strap changed without override");
  override_a: assert property (@(posedge clock) disable iff (!rst_n)
    pg_ok && pg_ok_d_ff && dbg_override_en |=> strap_ff == $past(dbg_override_val)) // RULE5
    else $error("debug override ignored");
  debug_en_a: assert property (@(posedge clock) disable iff (!rst_n)
    valid_ff && !factory_test_select |=> dbg_ff == !$past(strap_ff.debug_bus_n)) // RULE6
    else $error("debug enable wrong");
  test_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    factory_test_select |=> !dbg_ff && aux_oe_ff == 3'h0) // RULE11
    else $error("activity in test mode");
  no_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
    !valid_ff && st_ff == SLL_IDLE |=> !sda_oe_ff && aux_oe_ff == 3'h0) // RULE2
    else $error("strap pin driven before capture");
  eeprom_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pg_ok) && eeprom_select_strap_pin |=> st_ff == SLL_IDLE) // RULE8
    else $error("eeprom load without strap");
  aux_mux_a: assert property (@(posedge clock) disable iff (!rst_n)
    aux_pwm_sel[0] |=> aux_o_ff[0] == $past(aux_pwm[0])) // RULE10
    else $error("aux pwm mux wrong");
  c_capture: cover property (@(posedge clock) $rose(valid_ff));
  c_eeprom: cover property (@(posedge clock) st_ff == SLL_DONE);
  c_override: cover property (@(posedge clock) valid_ff && dbg_override_en);
  c_test: cover property (@(posedge clock) valid_ff && factory_test_select);
endmodule

//--- dv/sll_eeprom.sv
`timescale 1ns/1ps
module sll_eeprom
  import sll_pkg::*;
(
  // Presence and content.
  input wire logic present,
  input wire logic [7:0] data,
  // Bus lines.
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  output logic sda
);
  logic [4:0] n = 5'h1f;
  logic [7:0] sh = 8'h0;
  logic drv = 1'h0;
  logic val = 1'h1;
  // A released line reads high through the pull-up.
  assign sda = sda_oe ? sda_out : (drv ? val : 1'h1);
  // Start clears the bit count, stop parks it.
  always @(sda)
    if (scl)
    begin
      n = sda ? 5'h1f : 5'h0;
      drv = 1'h0;
    end
  always @(posedge scl)
  begin
    if (n < 5'h8)
      sh = {sh[6:0], sda};
    if (n != 5'h1f)
      n = n + 5'h1;
  end
  always @(negedge scl)
    if (n == 5'h8)
    begin
      drv = present && sh == {SLL_EEP_ADDR, 1'h1};
      val = 1'h0;
    end
    else if (drv && n > 5'h8 && n < 5'h11)
      val = data[3'(5'h10 - n)];
    else
      drv = 1'h0;
endmodule

//--- dv/strap_latch_loader_test.sv
`timescale 1ns/1ps
module strap_latch_loader_test
  import sll_pkg::*;
;
  logic clock, rst_n, power_ok_in, factory_test_select, debug_strap_pin, reserved_strap_pin;
  logic eeprom_select_strap_pin, dbg_override_en, sdata_gpio_out, sdata_gpio_oe, sdata_pwm, sda, sda_out;
  logic sda_oe, scl, straps_valid, debug_bus_enable, test_mode_active, eeprom_fallback, eep_present;
  logic [1:0] sdata_mode;
  logic [2:0] aux_pwm_sel, aux_gpio_out, aux_gpio_oe, aux_pwm, aux_out, aux_oe;
  logic [7:0] eep_byte;
  sll_strap_t dbg_override_val, strap_value;
  logic [19:0] rows [4];
  int err_count, checks_done, i;

  sll_strap_loader sll_strap_loader_inst (.clock, .rst_n, .power_ok_in, .factory_test_select, .debug_strap_pin,
    .reserved_strap_pin, .eeprom_select_strap_pin, .dbg_override_en, .dbg_override_val, .sdata_mode,
    .sdata_gpio_out, .sdata_gpio_oe, .strap_serial_data_in(sda), .strap_serial_data_out(sda_out),
    .strap_serial_data_oe(sda_oe), .strap_scl_out(scl), .aux_pwm_sel, .aux_gpio_out, .aux_gpio_oe, .aux_pwm,
    .sdata_pwm, .aux_out, .aux_oe, .strap_value, .straps_valid, .debug_bus_enable, .test_mode_active,
    .eeprom_fallback);
  sll_eeprom sll_eeprom_inst (.present(eep_present), .data(eep_byte), .scl, .sda_out, .sda_oe, .sda);

  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize();
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic power_up(input logic dbg, input logic eep);
    rst_n <= 1'h0;
    power_ok_in <= 1'h0;
    debug_strap_pin <= dbg;
    reserved_strap_pin <= 1'h1;
    eeprom_select_strap_pin <= eep;
    repeat (12) @(posedge clock);
    #1 check(16'({sda_oe, aux_oe}), 16'h0);
    @(posedge clock);
    rst_n <= 1'h1;
    power_ok_in <= 1'h1;
    repeat (6) @(posedge clock);
    #1 check(16'(straps_valid), 16'h0);
    repeat (6) @(posedge clock);
    #1 if (eep) check(16'(straps_valid), 16'h1);
  endtask

  task automatic wait_load(input logic [2:0] exp, input logic fb);
    int n;
    for (n = 0; n < 45000 && !(strap_value === exp && eeprom_fallback === fb); n++)
      @(negedge clock);
    check(16'({strap_value, eeprom_fallback}), 16'({exp, fb}));
    if (n == 45000)
    begin
      err_count++;
      summarize();
    end
  endtask

  initial
  begin
    {rst_n, power_ok_in, factory_test_select, debug_strap_pin, reserved_strap_pin} = 5'h0;
    {eeprom_select_strap_pin, dbg_override_en, sdata_gpio_out, sdata_gpio_oe, sdata_pwm} = 5'h3;
    dbg_override_val = 3'h7;
    sdata_mode = SLL_PIN_GPIO;
    {aux_pwm_sel, aux_gpio_out, aux_gpio_oe, aux_pwm} = 12'h17a;
    eep_present = 1'h0;
    eep_byte = 8'h32;
    err_count = 0;
    checks_done = 0;
    // Each row: debug pin, test, pin mode, pwm select, then the expected status and pin outputs.
    rows[0] = {1'h0, 1'h0, SLL_PIN_GPIO, 3'h0, 13'h0ebd};
    rows[1] = {1'h1, 1'h0, SLL_PIN_PWM, 3'h7, 13'h1cfa};
    rows[2] = {1'h0, 1'h1, SLL_PIN_GPIO, 3'h3, 13'h0d00};
    rows[3] = {1'h1, 1'h0, SLL_PIN_I2C, 3'h3, 13'h1c3e};
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock);
      {factory_test_select, sdata_mode, aux_pwm_sel} <= rows[i][18:13];
      power_up(rows[i][19], 1'h1);
      check(16'({strap_value, debug_bus_enable, test_mode_active, sda_oe, sda_oe & sda_out, aux_oe,
        aux_oe & aux_out}), 16'(rows[i][12:0]));
    end
    @(posedge clock);
    debug_strap_pin <= 1'h0;
    dbg_override_val <= 3'h2;
    aux_pwm_sel <= 3'h0;
    aux_gpio_out <= 3'h2;
    repeat (3) @(posedge clock);
    #1 check(16'({strap_value, aux_out}), 16'h3a);
    @(posedge clock);
    dbg_override_en <= 1'h1;
    repeat (3) @(posedge clock);
    #1 check(16'({strap_value, debug_bus_enable}), 16'h5);
    @(posedge clock);
    dbg_override_en <= 1'h0;
    power_ok_in <= 1'h0;
    repeat (4) @(posedge clock);
    #1 check(16'(straps_valid), 16'h0);
    @(posedge clock);
    power_ok_in <= 1'h1;
    repeat (6) @(posedge clock);
    power_ok_in <= 1'h0;
    repeat (10) @(posedge clock);
    #1 check(16'(straps_valid), 16'h0);
    @(posedge clock);
    eep_present <= 1'h1;
    power_up(1'h1, 1'h0);
    wait_load(3'h2, 1'h0);
    @(posedge clock);
    #1 check(16'(debug_bus_enable), 16'h1);
    @(posedge clock);
    eep_present <= 1'h0;
    power_up(1'h1, 1'h0);
    wait_load(3'h7, 1'h1);
    summarize();
  end
endmodule
